// [rtl/ais_map.svh]
/*
   Register offsets, event and limit codes, field positions and timing constants
   of the analog input channel scanner. Included by the scanner package
   users; assumes nothing else.
*/
`ifndef AIS_MAP_SVH
`define AIS_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define AIS_OFS_CTRL      8'h00
`define AIS_OFS_CHAN_EN   8'h04
`define AIS_OFS_STATUS    8'h08
`define AIS_OFS_CLEAR     8'h0C
`define AIS_OFS_IRQ_EN    8'h10
`define AIS_OFS_EVENT     8'h14
`define AIS_OFS_AVG       8'h18
`define AIS_OFS_CAL       8'h1C
`define AIS_OFS_FAULT     8'h20
`define AIS_OFS_DATA      8'h40

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define AIS_CTRL_RESTART  0
`define AIS_CTRL_SYNC     1
`define AIS_CTRL_LOOP     2

// ----------------------------------------------------------------------
// status / interrupt fields
// ----------------------------------------------------------------------
`define AIS_ST_INIT_ERR   0
`define AIS_ST_OVER       1
`define AIS_ST_UNDER      2
`define AIS_ST_OPEN       3
`define AIS_ST_PASS       4
`define AIS_ST_W          5

// ----------------------------------------------------------------------
// averaging register fields
// ----------------------------------------------------------------------
`define AIS_AVG_SHIFT_LSB 16
`define AIS_AVG_SHIFT_W   3
`define AIS_AVG_SHIFT_MAX 3'h7

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define AIS_INIT_ERR_CODE 32'h84C10000
`define AIS_OVER_CODE     16'hFF00
`define AIS_UNDER_CODE    16'h0100
`define AIS_OPEN_CODE     16'h0080
`define AIS_RESP_OKAY     2'h0
`define AIS_RESP_SLVERR   2'h2
`define AIS_CLK_NS        50
`define AIS_FREERUN_NS    10000

`endif

// [rtl/ais_pkg.sv]
/*
   Types of the analog input channel scanner.
   Does not include the map header; the state codes are set here.
*/
package ais_pkg;

   // ----------------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      AIS_S_INIT  = 3'b000,
      AIS_S_IDLE  = 3'b001,
      AIS_S_START = 3'b010,
      AIS_S_WAIT  = 3'b011,
      AIS_S_NEXT  = 3'b100,
      AIS_S_ERROR = 3'b101
   } ais_state_t;

   typedef logic [1:0] ais_resp_t;

endpackage

// [rtl/ais_scan.sv]
/*
   Analog input channel scanner: steps the converter through enabled
   channels, averages, calibrates, flags faults, AXI4-Lite registers.
   Assumes a converter front end that answers conv_start with conv_done
   and a sample, and a unit-bus sync tick for synchronous refresh.
*/
// Added by the designer: the address map and the AXI4-Lite register port.
//
// Behaviour
// - channels are converted one after another in a fixed order.
// - disabled channels are skipped, never converted; here chan_en_cfg is only loaded into chan_en_act at reset or restart.
// - disabled channels raise no fault flags at all.
// - pass time shrinks with fewer enabled channels; no idle slots.
// - each channel has its own independent enable bit.
// - enable bit true means enabled; all channels enabled after reset.
// - keep one channel enabled; none enabled raises init error event code.
// - asynchronous mode refreshes on an own free-running period.
// - synchronous mode samples on the shared unit-bus sync tick.
// - averaging channels report the mean over the set window.
// - averaging only in asynchronous mode, never in synchronous mode.
// - open-wire detection only for current-loop 4 to 20 mA variants.
// - flag over-range or under-range outside the convertible span.
// - subtract a user calibration offset from converted values.
`timescale 1ns/1ps
`include "ais_map.svh"

module ais_scan #(
   parameter int N       = 8,   // input channels
   parameter int DW      = 16,  // converter sample width
   parameter int ACC_W   = 24   // averaging accumulator width
) (
   input  wire logic                   aclk,          // system clock
   input  wire logic                   aresetn,       // sync reset, low
   // axi4-lite slave
   input  wire logic [7:0]             s_axi_awaddr,  // write address
   input  wire logic                   s_axi_awvalid, // write address valid
   output logic                        s_axi_awready, // write address ready
   input  wire logic [31:0]            s_axi_wdata,   // write data
   input  wire logic [3:0]             s_axi_wstrb,   // byte strobes
   input  wire logic                   s_axi_wvalid,  // write data valid
   output logic                        s_axi_wready,  // write data ready
   output ais_pkg::ais_resp_t          s_axi_bresp,   // write response
   output logic                        s_axi_bvalid,  // write response valid
   input  wire logic                   s_axi_bready,  // write response ready
   input  wire logic [7:0]             s_axi_araddr,  // read address
   input  wire logic                   s_axi_arvalid, // read address valid
   output logic                        s_axi_arready, // read address ready
   output logic [31:0]                 s_axi_rdata,   // read data
   output ais_pkg::ais_resp_t          s_axi_rresp,   // read response
   output logic                        s_axi_rvalid,  // read data valid
   input  wire logic                   s_axi_rready,  // read data ready
   // converter front end
   output logic                        conv_start,    // start pulse
   output logic [$clog2(N)-1:0]        conv_channel,  // channel to convert
   input  wire logic                   conv_done,     // sample ready pulse
   input  wire logic [DW-1:0]          conv_data,     // raw sample code
   // unit bus
   input  wire logic                   sync_tick,     // sync refresh tick
   output logic                        irq            // level interrupt
);
   import ais_pkg::*;

   localparam int CW = $clog2(N);
   localparam int FREERUN_CYC = (`AIS_FREERUN_NS + `AIS_CLK_NS - 1) / `AIS_CLK_NS;
   localparam int TW = $clog2(FREERUN_CYC + 1);

   if (N < 2 || N > 8 || DW != 16 || ACC_W < DW + 7 || ACC_W > 32) begin : g_bad_param
      $error("ais_scan: unsupported parameters");
   end

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // next enabled channel in cyclic order after cur
   function automatic logic [CW-1:0] next_ch(input logic [N-1:0] m,
                                             input logic [CW-1:0] cur);
      logic found;
      int   j;
      next_ch = cur;
      found   = 1'b0;
      for (int i = 1; i <= N; i++) begin
         j = (int'(cur) + i) % N;
         if (!found && m[j]) begin
            next_ch = CW'(j);
            found   = 1'b1;
         end
      end
   endfunction

   // byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            old_v[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      merge = old_v;
   endfunction

   // ----------------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------------
   ais_state_t             state;
   logic                   sync_mode;
   logic                   loop_variant;
   logic                   restart;
   logic [N-1:0]           chan_en_cfg;
   logic [N-1:0]           chan_en_act;
   logic [N-1:0]           avg_en;
   logic [`AIS_AVG_SHIFT_W-1:0] avg_shift;
   logic [DW-1:0]          cal_offset;
   logic [`AIS_ST_W-1:0]   status;
   logic [`AIS_ST_W-1:0]   irq_en;
   logic [`AIS_ST_W-1:0]   next_set;
   logic [N-1:0]           flt_over;
   logic [N-1:0]           flt_under;
   logic [N-1:0]           flt_open;
   logic [DW-1:0]          data  [N];
   logic [ACC_W-1:0]       acc   [N];
   logic [7:0]             cnt   [N];
   logic [TW-1:0]          free_cnt;
   logic                   free_tick;

   logic                   wr_fire;
   logic                   rd_fire;
   logic [31:0]            wd;
   logic [DW-1:0]          cal_val;
   logic                   do_avg;
   logic [7:0]             win_last;
   logic [ACC_W-1:0]       acc_sum;

   assign wr_fire  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_fire  = s_axi_arvalid && s_axi_arready;
   assign wd       = s_axi_wdata;
   assign cal_val  = conv_data - cal_offset;
   assign do_avg   = avg_en[conv_channel] && !sync_mode;
   assign win_last = 8'((1 << avg_shift) - 1);
   assign acc_sum  = acc[conv_channel] + ACC_W'(cal_val);

   // ----------------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------------
   // take address and data together, answer one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `AIS_RESP_OKAY;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (s_axi_awaddr)
               `AIS_OFS_CTRL, `AIS_OFS_CHAN_EN, `AIS_OFS_CLEAR, `AIS_OFS_IRQ_EN,
               `AIS_OFS_AVG, `AIS_OFS_CAL: s_axi_bresp <= `AIS_RESP_OKAY;
               default:                    s_axi_bresp <= `AIS_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_mode    <= 1'b0;
         loop_variant <= 1'b0;
         restart      <= 1'b0;
         chan_en_cfg  <= {N{1'b1}};
         avg_en       <= '0;
         avg_shift    <= '0;
         cal_offset   <= '0;
         irq_en       <= '0;
      end else begin
         restart <= 1'b0;
         if (wr_fire) begin
            case (s_axi_awaddr)
               `AIS_OFS_CTRL: begin
                  if (s_axi_wstrb[0]) begin
                     restart      <= wd[`AIS_CTRL_RESTART];
                     sync_mode    <= wd[`AIS_CTRL_SYNC];
                     loop_variant <= wd[`AIS_CTRL_LOOP];
                  end
               end
               `AIS_OFS_CHAN_EN: chan_en_cfg <= N'(merge(32'(chan_en_cfg), wd,
                                                         s_axi_wstrb));
               `AIS_OFS_IRQ_EN: irq_en <= `AIS_ST_W'(merge(32'(irq_en), wd, s_axi_wstrb));
               `AIS_OFS_AVG: begin
                  if (s_axi_wstrb[0]) begin
                     avg_en <= wd[N-1:0];
                  end
                  if (s_axi_wstrb[2]) begin
                     avg_shift <= wd[`AIS_AVG_SHIFT_LSB +: `AIS_AVG_SHIFT_W];
                  end
               end
               `AIS_OFS_CAL: cal_offset <= DW'(merge(32'(cal_offset), wd, s_axi_wstrb));
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------------
   // decode on the address beat, data the cycle after
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `AIS_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `AIS_RESP_OKAY;
            s_axi_rdata  <= '0;
            case (s_axi_araddr)
               `AIS_OFS_CTRL:    s_axi_rdata <= 32'({loop_variant, sync_mode, 1'b0});
               `AIS_OFS_CHAN_EN: s_axi_rdata <= 32'(chan_en_cfg);
               `AIS_OFS_STATUS:  s_axi_rdata <= 32'(status);
               `AIS_OFS_CLEAR:   s_axi_rdata <= '0;                    // write-only
               `AIS_OFS_IRQ_EN:  s_axi_rdata <= 32'(irq_en);
               `AIS_OFS_EVENT:   s_axi_rdata <= status[`AIS_ST_INIT_ERR] ?
                                                `AIS_INIT_ERR_CODE : '0;
               `AIS_OFS_AVG:     s_axi_rdata <= 32'({avg_shift, 8'h00, 8'(avg_en)});
               `AIS_OFS_CAL:     s_axi_rdata <= 32'(cal_offset);
               `AIS_OFS_FAULT:   s_axi_rdata <= 32'({8'(flt_open), 8'(flt_under),
                                                     8'(flt_over)});
               default: begin
                  if (s_axi_araddr >= `AIS_OFS_DATA &&
                      s_axi_araddr < 8'(`AIS_OFS_DATA + 4 * N) &&
                      s_axi_araddr[1:0] == 2'h0) begin
                     s_axi_rdata <= 32'(data[s_axi_araddr[2 +: CW]]);
                  end else begin
                     s_axi_rresp <= `AIS_RESP_SLVERR;
                  end
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // refresh timing
   // ----------------------------------------------------------------------
   // free-running refresh period, independent of the unit bus
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         free_cnt  <= '0;
         free_tick <= 1'b0;
      end else begin
         free_tick <= (free_cnt == TW'(FREERUN_CYC - 1));
         free_cnt  <= (free_cnt == TW'(FREERUN_CYC - 1)) ? '0 : free_cnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   // walks enabled channels, one conversion slot each
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state        <= AIS_S_INIT;
         chan_en_act  <= '0;
         conv_start   <= 1'b0;
         conv_channel <= '0;
      end else begin
         conv_start <= 1'b0;
         if (restart) begin
            state <= AIS_S_INIT;
         end else begin
            case (state)
               AIS_S_INIT: begin
                  chan_en_act  <= chan_en_cfg;
                  conv_channel <= next_ch(chan_en_cfg, CW'(N - 1));
                  state        <= (chan_en_cfg == '0) ? AIS_S_ERROR : AIS_S_IDLE;
               end
               AIS_S_IDLE: begin
                  if (sync_mode ? sync_tick : free_tick) begin
                     state <= AIS_S_START;
                  end
               end
               AIS_S_START: begin
                  conv_start <= 1'b1;
                  state      <= AIS_S_WAIT;
               end
               AIS_S_WAIT: begin
                  if (conv_done) begin
                     state <= AIS_S_NEXT;
                  end
               end
               AIS_S_NEXT: begin
                  // skip disabled channels without spending a slot
                  conv_channel <= next_ch(chan_en_act, conv_channel);
                  if (next_ch(chan_en_act, conv_channel) <= conv_channel) begin
                     state <= AIS_S_IDLE;
                  end else begin
                     state <= AIS_S_START;
                  end
               end
               AIS_S_ERROR: state <= AIS_S_ERROR;                  // held until restart
               default:     state <= AIS_S_INIT;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // sample path: calibration, averaging, fault checks
   // ----------------------------------------------------------------------
   // only the channel under conversion is ever checked
   generate
      for (genvar c = 0; c < N; c++) begin : g_ch
         always_ff @(posedge aclk) begin
            if (!aresetn || restart) begin
               data[c]      <= '0;
               acc[c]       <= '0;
               cnt[c]       <= '0;
               flt_over[c]  <= 1'b0;
               flt_under[c] <= 1'b0;
               flt_open[c]  <= 1'b0;
            end else if (state == AIS_S_WAIT && conv_done &&
                         conv_channel == CW'(c) && chan_en_act[c]) begin
               flt_over[c]  <= conv_data >= `AIS_OVER_CODE;
               flt_under[c] <= conv_data <= `AIS_UNDER_CODE;
               flt_open[c]  <= loop_variant && conv_data < `AIS_OPEN_CODE;
               if (!do_avg) begin
                  data[c] <= cal_val;
                  acc[c]  <= '0;
                  cnt[c]  <= '0;
               end else if (cnt[c] == win_last) begin
                  data[c] <= DW'(acc_sum >> avg_shift);
                  acc[c]  <= '0;
                  cnt[c]  <= '0;
               end else begin
                  acc[c] <= acc_sum;
                  cnt[c] <= cnt[c] + 8'h01;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------------
   // events of this cycle
   always_comb begin
      next_set = '0;
      next_set[`AIS_ST_INIT_ERR] = (state == AIS_S_INIT) && (chan_en_cfg == '0) &&
                                   !restart;
      if (state == AIS_S_WAIT && conv_done && chan_en_act[conv_channel]) begin
         next_set[`AIS_ST_OVER]  = conv_data >= `AIS_OVER_CODE;
         next_set[`AIS_ST_UNDER] = conv_data <= `AIS_UNDER_CODE;
         next_set[`AIS_ST_OPEN]  = loop_variant && conv_data < `AIS_OPEN_CODE;
      end
      next_set[`AIS_ST_PASS] = (state == AIS_S_NEXT) && !restart &&
                               (next_ch(chan_en_act, conv_channel) <= conv_channel);
   end

   // sticky bits, a set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status <= '0;
         irq    <= 1'b0;
      end else begin
         if (wr_fire && s_axi_awaddr == `AIS_OFS_CLEAR && s_axi_wstrb[0]) begin
            status <= (status & ~wd[`AIS_ST_W-1:0]) | next_set;
         end else begin
            status <= status | next_set;
         end
         irq <= |(status & irq_en);
      end
   end

endmodule // ais_scan

// [bench/ais_conv_model.sv]
/* converter front end model: answers each start pulse lat+2 cycles later.
   assumes one conversion at a time from the scanner. */
`timescale 1ns/1ps
module ais_conv_model (
   input  wire logic         aclk,         // clock
   input  wire logic         aresetn,      // reset, low
   input  wire logic         conv_start,   // start pulse
   input  wire logic [2:0]   conv_channel, // channel asked for
   input  wire logic [2:0]   lat,          // extra delay
   input  wire logic [127:0] codes,        // code per channel
   output logic              conv_done,    // sample ready
   output logic [15:0]       conv_data     // sample code
);
   logic [3:0] cnt;
   // -----------
   // answer
   // -----------
   // data toggles while not valid, so stale values never match
   always_ff @(posedge aclk) begin
      conv_done <= 1'h0;
      conv_data <= ~conv_data;
      if (!aresetn) begin
         cnt       <= 4'h0;
         conv_data <= 16'h0000;
      end else if (conv_start)
         cnt <= {1'h0, lat} + 4'h1;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      if (aresetn && cnt == 4'h1) begin
         conv_done <= 1'h1;
         conv_data <= codes[conv_channel*16 +: 16];
      end
   end
endmodule // ais_conv_model

// [bench/ais_scan_monitor.sv]
/* assertions on the scanner's bus handshakes and converter pacing.
   bound onto ais_scan; sees its ports only. */
`timescale 1ns/1ps
module ais_scan_monitor #(
   parameter int N = 8 // input channels
) (
   input wire logic                 aclk,          // clock
   input wire logic                 aresetn,       // reset, low
   input wire logic                 s_axi_awvalid, // aw valid
   input wire logic                 s_axi_awready, // aw ready
   input wire logic                 s_axi_wvalid,  // w valid
   input wire logic                 s_axi_wready,  // w ready
   input wire logic                 s_axi_bvalid,  // b valid
   input wire logic                 s_axi_bready,  // b ready
   input wire logic                 s_axi_arvalid, // ar valid
   input wire logic                 s_axi_arready, // ar ready
   input wire logic                 s_axi_rvalid,  // r valid
   input wire logic                 s_axi_rready,  // r ready
   input wire logic                 conv_start,    // start pulse
   input wire logic [$clog2(N)-1:0] conv_channel,  // channel
   input wire logic                 conv_done      // sample ready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // -----------
   // steps
   // -----------
   sequence s_wr_ans; s_axi_awready && s_axi_wready ##1 s_axi_bvalid; endsequence
   sequence s_rd_ans; s_axi_arready ##1 s_axi_rvalid; endsequence
   sequence s_quiet; !conv_start [*2]; endsequence
   property p_wr;
      s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid |=> s_wr_ans;
   endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_rd; s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_rd_ans; endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_pair; s_axi_awready == s_axi_wready; endproperty
   a_pair: assert property (p_pair) else $error("aw and w taken apart");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
   property p_pulse; conv_start |=> !conv_start; endproperty
   a_pulse: assert property (p_pulse) else $error("start too long");
   property p_chold; conv_start |-> $stable(conv_channel); endproperty
   a_chold: assert property (p_chold) else $error("channel moved at start");
   property p_gap; conv_done |=> s_quiet; endproperty
   a_gap: assert property (p_gap) else $error("start too soon after done");
endmodule // ais_scan_monitor

bind ais_scan ais_scan_monitor #(.N(N)) u_ais_scan_monitor (.*);

// [bench/testbench.sv]
/* top bench: scanner, converter model, random enables and codes.
   assumes the monitor binds itself onto the scanner. */
`timescale 1ns/1ps
`include "ais_map.svh"
module testbench;
   import ais_pkg::*;
   localparam ais_resp_t ok = `AIS_RESP_OKAY;
   localparam ais_resp_t se = `AIS_RESP_SLVERR;
   logic         aclk = 1'h0, aresetn = 1'h0, sync_tick = 1'h0;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, m;
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0000F13A;
   logic [3:0]   s_axi_wstrb = 4'hF;
   logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   ais_resp_t    s_axi_bresp, s_axi_rresp;
   logic         conv_start, conv_done, irq;
   logic [2:0]   conv_channel, lat = 3'h0;
   logic [15:0]  conv_data;
   logic [127:0] codes;
   logic [33:0]  rq[$], wq[$];
   logic [2:0]   cq[$];
   int           err_count = 0, total_checks = 0;
   ais_scan u_ais_scan (.*);
   ais_conv_model u_ais_conv_model (.*);
   always #25 aclk = ~aclk;
   // -----------
   // helpers
   // -----------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input ais_resp_t r);
      wq.push_back({32'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do @(posedge aclk); while (!s_axi_awready);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask
   // notes one pass of channels, ticks if asked, waits for it to drain
   task automatic pass(input logic [7:0] en, input logic tk);
      for (int c = 0; c < 8; c++)
         if (en[c])
            cq.push_back(3'(c));
      lat <= 3'(rnd());
      repeat (4) @(posedge aclk);
      sync_tick <= tk;
      @(posedge aclk);
      sync_tick <= 1'h0;
      for (int i = 0; i < 900 && cq.size() > 0; i++)
         @(posedge aclk);
      chk(34'(cq.size()), 34'h0);
      repeat (20) @(posedge aclk);
   endtask
   task automatic ck_irq(input logic e);
      repeat (2) @(posedge aclk);
      chk({33'h0, irq}, {33'h0, e});
   endtask
   // watcher: oldest note against each answer
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready)
         chk({32'h0, s_axi_bresp}, wq.pop_front());
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (conv_start)
         chk({31'h0, conv_channel}, cq.size() > 0 ? {31'h0, cq.pop_front()} : 34'hx);
   end
   // hang guard, far beyond the expected run
   initial begin
      #2000000;
      err_count++;
      wrap_up();
   end
   // -----------
   // scenarios
   // -----------
   initial begin
      for (int c = 0; c < 8; c++)
         codes[c*16 +: 16] = 16'h0200 + 16'(rnd() & 32'h7FFF);
      codes[47:0] = 48'h0040_FFF0_1234;
      m = (8'(rnd()) & 8'hFD) | 8'h01;
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      rd(`AIS_OFS_CHAN_EN, {ok, 32'h000000FF});
      rd(8'h3C, {se, 32'h0});
      wr(8'h3C, 32'h1, se);
      wr(`AIS_OFS_CAL, 32'h10, ok);
      wr(`AIS_OFS_AVG, 32'h10001, ok);
      wr(`AIS_OFS_CTRL, 32'h7, ok);
      pass(8'hFF, 1'h1);
      rd(`AIS_OFS_DATA, {ok, 32'h1224});
      rd(`AIS_OFS_FAULT, {ok, 32'h00040402});
      rd(`AIS_OFS_STATUS, {ok, 32'h1E});
      wr(`AIS_OFS_CHAN_EN, {24'h0, m}, ok);
      pass(8'hFF, 1'h1);
      wr(`AIS_OFS_CTRL, 32'h3, ok);
      pass(m, 1'h1);
      pass(m, 1'h1);
      rd(`AIS_OFS_DATA + 8'h4, {ok, 32'h0});
      rd(`AIS_OFS_FAULT, {ok, m[2] ? 32'h400 : 32'h0});
      wr(`AIS_OFS_CTRL, 32'h1, ok);
      pass(m, 1'h0);
      rd(`AIS_OFS_DATA, {ok, 32'h0});
      pass(m, 1'h0);
      rd(`AIS_OFS_DATA, {ok, 32'h1224});
      wr(`AIS_OFS_IRQ_EN, 32'h1, ok);
      wr(`AIS_OFS_CHAN_EN, 32'h0, ok);
      wr(`AIS_OFS_CTRL, 32'h3, ok);
      pass(8'h00, 1'h1);
      wr(`AIS_OFS_CLEAR, 32'h1E, ok);
      rd(`AIS_OFS_STATUS, {ok, 32'h1});
      rd(`AIS_OFS_EVENT, {ok, `AIS_INIT_ERR_CODE});
      ck_irq(1'h1);
      wr(`AIS_OFS_IRQ_EN, 32'h0, ok);
      ck_irq(1'h0);
      wr(`AIS_OFS_IRQ_EN, 32'h1, ok);
      ck_irq(1'h1);
      wr(`AIS_OFS_CHAN_EN, 32'hFF, ok);
      wr(`AIS_OFS_CTRL, 32'h3, ok);
      wr(`AIS_OFS_CLEAR, 32'h1, ok);
      ck_irq(1'h0);
      rd(`AIS_OFS_EVENT, {ok, 32'h0});
      wrap_up();
   end
endmodule // testbench
